// ===== bench/pmag_ext_prog.sv
// Purpose: external programmer model on the serial programming side
// Assumes: requests launched at the falling edge, taken at the rising edge
// Notes:   released address and data lines show the inverse value
`timescale 1ns/1ps
module pmag_ext_prog (
    input  wire logic  core_clk,
    input  wire logic  extAllow,
    output logic       extReadReq,
    output logic       extWriteReq,
    output logic       extEepromSel,
    output logic [21:0] extAddr,
    output logic [7:0] extWrData,
    output logic       extChipErase,
    output logic       extBlockErase,
    output logic [2:0] extEraseBlock,
    output logic       progEntryPin,
    output logic       highProgVoltage
);
    // entry pin low in normal operation
    initial begin
        {extReadReq, extWriteReq, extEepromSel, extChipErase, extBlockErase} = 5'h0;
        {extAddr, extWrData, extEraseBlock, progEntryPin, highProgVoltage} = '0;
    end
    // session entry by high voltage or entry pin
    task automatic enter(input bit hv);
        @(negedge core_clk);
        highProgVoltage = hv;
        progEntryPin = !hv;
        repeat (4) @(negedge core_clk);
    endtask
    task automatic leave;
        @(negedge core_clk);
        {highProgVoltage, progEntryPin} = 2'h0;
        repeat (4) @(negedge core_clk);
    endtask
    // One request held from a falling edge to the next, across its rising edge
    task automatic access(input logic [21:0] a, input logic [7:0] d, input bit wr, eep,
                          output logic ok);
        @(negedge core_clk);
        {extAddr, extWrData, extEepromSel, extWriteReq, extReadReq} = {a, d, eep, wr, !wr};
        @(posedge core_clk);
        ok = extAllow;
        @(negedge core_clk);
        {extAddr, extWrData, extWriteReq, extReadReq} = {~a, ~d, 2'h0};
    endtask
    // erase started only by the programmer
    task automatic erase(input bit chip, input logic [2:0] blk);
        @(negedge core_clk);
        {extChipErase, extBlockErase, extEraseBlock} = {chip, !chip, blk};
        @(negedge core_clk);
        {extChipErase, extBlockErase} = 2'h0;
    endtask
endmodule

// ===== bench/pmag_guard_properties.sv
// Purpose: port-level checks for the access guard
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   outcomes that hang on lock state are judged by the bench
`timescale 1ns/1ps
module pmag_guard_checker (
    input wire logic        core_clk,
    input wire logic        resetn,
    input wire logic        tableReadOp,
    input wire logic        tableWriteOp,
    input wire logic [21:0] tablePtr,
    input wire logic [21:0] execPc,
    input wire logic [7:0]  memRdData,
    input wire logic [7:0]  tableRdData,
    input wire logic        memWrAllow,
    input wire logic        cpuEepromReq,
    input wire logic        cpuEepromAllow,
    input wire logic        highProgVoltage,
    input wire logic        progEntryPin,
    input wire logic        progMode,
    input wire logic        progEntryPinGpio
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // Block one on both sides, and the ID window
    wire logic inBlk1 = tablePtr[21:14] == 8'h01 && execPc[21:14] == 8'h01;
    wire logic inId   = tablePtr[21:3] == 19'h4_0000;
    // Pins held long enough to pass the synchronisers
    sequence hvHeld; highProgVoltage [*4]; endsequence
    sequence pinsLow; (!highProgVoltage && !progEntryPin) [*3]; endsequence
    AST_IDLE_READ_ZERO: assert property (!tableReadOp |-> tableRdData == 8'h00)
        else $error("read data not zero while idle");
    AST_SAME_BLOCK_READ: assert property (tableReadOp && inBlk1 |-> tableRdData == memRdData)
        else $error("same-block read altered");
    AST_ID_WRITE: assert property (tableWriteOp && inId && !progMode |-> memWrAllow)
        else $error("ID write refused");
    AST_NO_WRITE_IDLE: assert property (!tableWriteOp |-> !memWrAllow)
        else $error("write allowed with no table write");
    AST_EEPROM_CPU: assert property (cpuEepromAllow == cpuEepromReq)
        else $error("CPU EEPROM access gated");
    AST_HV_ENTRY: assert property (hvHeld |-> progMode)
        else $error("high voltage did not enter programming");
    AST_IDLE_NO_PROG: assert property (pinsLow |-> !progMode)
        else $error("programming mode with pins idle");
    AST_GPIO_ONLY_HV: assert property ($changed(progEntryPinGpio) |-> $past(highProgVoltage))
        else $error("entry pin role changed outside HV session");
endmodule
bind pmag_guard pmag_guard_checker u_chk (
    .core_clk(core_clk), .resetn(resetn), .tableReadOp(tableReadOp),
    .tableWriteOp(tableWriteOp), .tablePtr(tablePtr), .execPc(execPc),
    .memRdData(memRdData), .tableRdData(tableRdData), .memWrAllow(memWrAllow),
    .cpuEepromReq(cpuEepromReq), .cpuEepromAllow(cpuEepromAllow),
    .highProgVoltage(highProgVoltage), .progEntryPin(progEntryPin),
    .progMode(progMode), .progEntryPinGpio(progEntryPinGpio)
);

// ===== bench/test_program_memory_access_guard.sv
// Purpose: directed tests of the access guard
// Assumes: default build with block three present
// Notes:   CPU ops judged mid-cycle, lock bytes read back by table read
`timescale 1ns/1ps
module test_program_memory_access_guard;
    logic        core_clk, resetn, tableReadOp, tableWriteOp, cpuEepromReq, ok;
    logic [21:0] tablePtr, execPc, extAddr;
    logic [7:0]  tableWrData, memRdData, tableRdData, extWrData;
    logic        memWrAllow, cfgWrAllow, cpuEepromAllow, extAllow, extReadReq, extWriteReq;
    logic        extEepromSel, extChipErase, extBlockErase, progEntryPin, highProgVoltage;
    logic [2:0]  extEraseBlock;
    logic        progMode, progEntryPinGpio, debugEnable, toolPinsReserved;
    int          err_total, total_checks;
    pmag_guard dut (
        .core_clk(core_clk), .resetn(resetn), .tableReadOp(tableReadOp),
        .tableWriteOp(tableWriteOp), .tablePtr(tablePtr), .execPc(execPc),
        .tableWrData(tableWrData), .memRdData(memRdData), .tableRdData(tableRdData),
        .memWrAllow(memWrAllow), .cfgWrAllow(cfgWrAllow), .cpuEepromReq(cpuEepromReq),
        .cpuEepromAllow(cpuEepromAllow), .extReadReq(extReadReq), .extWriteReq(extWriteReq),
        .extEepromSel(extEepromSel), .extAddr(extAddr), .extWrData(extWrData),
        .extAllow(extAllow), .extChipErase(extChipErase), .extBlockErase(extBlockErase),
        .extEraseBlock(extEraseBlock), .progEntryPin(progEntryPin),
        .highProgVoltage(highProgVoltage), .progMode(progMode),
        .progEntryPinGpio(progEntryPinGpio), .debugEnable(debugEnable),
        .toolPinsReserved(toolPinsReserved)
    );
    pmag_ext_prog prog (
        .core_clk(core_clk), .extAllow(extAllow), .extReadReq(extReadReq),
        .extWriteReq(extWriteReq), .extEepromSel(extEepromSel), .extAddr(extAddr),
        .extWrData(extWrData), .extChipErase(extChipErase), .extBlockErase(extBlockErase),
        .extEraseBlock(extEraseBlock), .progEntryPin(progEntryPin),
        .highProgVoltage(highProgVoltage)
    );
    // 25 MHz core clock
    initial begin
        core_clk = 0;
        forever #20 core_clk = ~core_clk;
    end
    task automatic check(input string what, input logic [7:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // One CPU table op launched at the falling edge
    task automatic cpu(input bit wr, input logic [21:0] ptr, pc, input logic [7:0] d);
        @(negedge core_clk);
        {tableReadOp, tableWriteOp, tablePtr, execPc} = {!wr, wr, ptr, pc};
        {tableWrData, memRdData} = {d, d};
        #5;
    endtask
    task automatic cfg(input logic [21:0] a, input logic [7:0] exp);
        cpu(0, a, 22'h00_0100, 8'h00);
        check("config byte", tableRdData, exp);
    endtask
    // Hang guard
    initial begin
        #200000;
        err_total++;
        tally_and_finish;
    end
    // Main sequence
    initial begin
        {resetn, tableReadOp, tableWriteOp, cpuEepromReq} = 4'h0;
        {tablePtr, execPc, tableWrData, memRdData} = '0;
        repeat (6) @(negedge core_clk);
        resetn = 1;
        for (int i = 8; i < 14; i++) cfg(22'h30_0000 + 22'(i), 8'hFF);
        cfg(22'h30_0006, 8'hFF);
        check("pin gpio", 8'(progEntryPinGpio), 8'h00);
        check("debug", 8'(debugEnable), 8'h00);
        cpu(0, 22'h00_4000, 22'h00_0100, 8'hA5); check("open read", tableRdData, 8'hA5);
        // Locks cleared from a high-voltage session
        prog.enter(1);
        prog.access(22'h30_000C, 8'hFD, 1, 0, ok);
        prog.access(22'h30_000A, 8'hFE, 1, 0, ok);
        prog.access(22'h30_0008, 8'hF7, 1, 0, ok);
        prog.access(22'h30_0009, 8'h7F, 1, 0, ok);
        prog.access(22'h30_000C, 8'hFF, 1, 0, ok);
        prog.access(22'h00_C000, 8'h00, 0, 0, ok); check("blk3 ext", 8'(ok), 8'h00);
        prog.access(22'h00_4000, 8'h00, 0, 0, ok); check("blk1 ext", 8'(ok), 8'h01);
        prog.access(22'h00_0010, 8'h00, 0, 1, ok); check("eeprom ext", 8'(ok), 8'h00);
        prog.leave;
        cfg(22'h30_000C, 8'hFD);
        cpu(0, 22'h00_4000, 22'h00_0100, 8'hA5); check("cross read", tableRdData, 8'h00);
        cpu(0, 22'h00_4000, 22'h00_4100, 8'hA5); check("own read", tableRdData, 8'hA5);
        cpu(0, 22'h20_0003, 22'h00_0100, 8'h3C); check("id read", tableRdData, 8'h3C);
        cpu(1, 22'h00_0800, 22'h00_4000, 8'h11); check("blk0 wr", 8'(memWrAllow), 8'h00);
        cpu(1, 22'h00_07FF, 22'h00_4000, 8'h11); check("boot wr", 8'(memWrAllow), 8'h01);
        cpu(1, 22'h20_0007, 22'h00_0100, 8'h11); check("id wr", 8'(memWrAllow), 8'h01);
        cpu(1, 22'h30_000A, 22'h00_0100, 8'hFD); check("cfg wr", 8'(cfgWrAllow), 8'h01);
        cpu(1, 22'h30_000B, 22'h00_0100, 8'hDF);
        @(negedge core_clk) cpuEepromReq = 1;
        #5 check("cpu eeprom", 8'(cpuEepromAllow), 8'h01);
        @(negedge core_clk) cpuEepromReq = 0;
        #5 check("cpu eeprom idle", 8'(cpuEepromAllow), 8'h00);
        @(negedge core_clk) cpuEepromReq = 1;
        cfg(22'h30_000A, 8'hFC);
        cfg(22'h30_000B, 8'hFF);
        // Config write lock set by the programmer only
        prog.enter(1);
        prog.access(22'h30_000B, 8'hDF, 1, 0, ok);
        prog.leave;
        cpu(1, 22'h30_000A, 22'h00_0100, 8'h00); check("cfg locked", 8'(cfgWrAllow), 8'h00);
        cfg(22'h30_000A, 8'hFC);
        // Block erase of block one, then chip erase
        prog.enter(1);
        prog.erase(0, 3'h1);
        prog.leave;
        cfg(22'h30_000C, 8'hFF);
        cfg(22'h30_000A, 8'hFE);
        prog.enter(1);
        prog.erase(1, 3'h0);
        prog.leave;
        cfg(22'h30_000B, 8'hFF);
        // Entry pin session cannot change its own enable
        prog.enter(0);
        check("lv entry", 8'(progMode), 8'h01);
        prog.access(22'h30_0006, 8'h7B, 1, 0, ok);
        prog.leave;
        check("lv kept", 8'(progEntryPinGpio), 8'h00);
        prog.enter(1);
        prog.access(22'h30_0006, 8'h7B, 1, 0, ok);
        prog.leave;
        check("pin freed", 8'(progEntryPinGpio), 8'h01);
        check("debug on", 8'(toolPinsReserved), 8'h01);
        prog.enter(0);
        check("lv gone", 8'(progMode), 8'h00);
        prog.leave;
        // Mid-run reset puts every lock and config byte back to erased
        @(negedge core_clk) resetn = 0;
        repeat (2) @(negedge core_clk);
        resetn = 1;
        cfg(22'h30_000C, 8'hFF);
        cfg(22'h30_0006, 8'hFF);
        check("lv reset", 8'(progEntryPinGpio), 8'h00);
        check("debug reset", 8'(debugEnable), 8'h00);
        tally_and_finish;
    end
endmodule

// ===== verilog/pmag_defs.svh
// Purpose: constants for the program memory access guard
// Assumes: byte addresses of 22 bits, 8-bit configuration bytes
// Notes:   included by bare name
`ifndef PMAG_DEFS_SVH
`define PMAG_DEFS_SVH
`define PMAG_ADDR_W          22
`define PMAG_BOOT_LAST       22'h00_07FF
`define PMAG_BLK0_LAST       22'h00_3FFF
`define PMAG_BLK1_LAST       22'h00_7FFF
`define PMAG_BLK2_LAST       22'h00_BFFF
`define PMAG_BLK3_LAST       22'h00_FFFF
`define PMAG_ID_FIRST        22'h20_0000
`define PMAG_ID_LAST         22'h20_0007
`define PMAG_CFG_FIRST       22'h30_0000
`define PMAG_CFG_LAST        22'h3F_FFFF
`define PMAG_REG_EXT_LO      22'h30_0008
`define PMAG_REG_EXT_HI      22'h30_0009
`define PMAG_REG_WR_LO       22'h30_000A
`define PMAG_REG_WR_HI       22'h30_000B
`define PMAG_REG_XRD_LO      22'h30_000C
`define PMAG_REG_XRD_HI      22'h30_000D
`define PMAG_REG_DBGPROG     22'h30_0006
`define PMAG_BIT_EEPROM      7
`define PMAG_BIT_BOOT        6
`define PMAG_BIT_CFGWR       5
`define PMAG_BIT_LVP         2
`define PMAG_BIT_DEBUG       7
`define PMAG_ERASED          8'hFF
`define PMAG_ZERO_BYTE       8'h00
`define PMAG_DBG_PINS        2
`define PMAG_DBG_STACK       2
`define PMAG_DBG_PROG_BYTES  512
`define PMAG_DBG_DATA_BYTES  10
`endif

// ===== verilog/pmag_guard.sv
// Purpose: access guard for program memory, EEPROM, config and ID space
// Assumes: CPU table ops and external programmer requests on core_clk
// Notes:   decisions are combinational, lock bytes held in flops
//
// Behaviour
// R01: Four 16K blocks, boot 2K split off
// R02: Fixed block address ranges, block three optional
// R03: Each block has three lock controls
// R04: Lock bytes at fixed configuration addresses
// R05: CPU table ops reach memory and config
// R06: External locks never affect CPU accesses
// R07: Write lock zero rejects table writes
// R08: Same-block table read returns true data
// R09: Cross-block read denied returns zeros
// R10: Lock bits only go one to zero
// R11: Only programmer erase sets bits back; the code also sets every lock byte back to all ones on resetn
// R12: EEPROM locks gate external reads, writes
// R13: CPU EEPROM access always allowed
// R14: Config write lock changed only externally
// R15: Eight ID bytes reachable both ways
// R16: ID bytes readable despite protection
// R17: Debug bit zero enables debugger resources
// R18: LOW_VOLT_PROG_ENABLE set dedicates entry pin
// R19: Entry pin high enters programming mode
// R20: LOW_VOLT_PROG_ENABLE erased state is one
// R21: High voltage always enters programming
// R22: LOW_VOLT_PROG_ENABLE changed only in HV session
// R23: Same-cycle checks, no stall
`timescale 1ns/1ps
`include "pmag_defs.svh"

module pmag_guard #(
    parameter bit HAS_BLOCK3 = 1'b1
) (
    input  wire logic                    core_clk,
    input  wire logic                    resetn,
    // CPU table operations
    input  wire logic                    tableReadOp,
    input  wire logic                    tableWriteOp,
    input  wire logic [`PMAG_ADDR_W-1:0] tablePtr,
    input  wire logic [`PMAG_ADDR_W-1:0] execPc,
    input  wire logic [7:0]              tableWrData,
    input  wire logic [7:0]              memRdData,
    output logic      [7:0]              tableRdData,
    output logic                         memWrAllow,
    output logic                         cfgWrAllow,
    input  wire logic                    cpuEepromReq,
    output logic                         cpuEepromAllow,
    // External programmer requests
    input  wire logic                    extReadReq,
    input  wire logic                    extWriteReq,
    input  wire logic                    extEepromSel,
    input  wire logic [`PMAG_ADDR_W-1:0] extAddr,
    input  wire logic [7:0]              extWrData,
    output logic                         extAllow,
    input  wire logic                    extChipErase,
    input  wire logic                    extBlockErase,
    input  wire logic [2:0]              extEraseBlock,
    // Pins
    input  wire logic                    progEntryPin,
    input  wire logic                    highProgVoltage,
    output logic                         progMode,
    output logic                         progEntryPinGpio,
    output logic                         debugEnable,
    output logic                         toolPinsReserved
);

    // Lock and config bytes, erased state is all ones
    logic [7:0] extLo_q, extHi_q, wrLo_q, wrHi_q, xrdLo_q, xrdHi_q, dbgProg_q;
    logic       hvSession_q;
    logic       entryS1_q, entryS2_q, hvS1_q, hvS2_q;

    logic       progActive;
    pmag_pkg::pmag_region_t tgtRegion, pcRegion, extRegion;

    // R01 block split and R02 range decode
    function automatic pmag_pkg::pmag_region_t regionOf(input logic [`PMAG_ADDR_W-1:0] a);
        pmag_pkg::pmag_region_t r;
        r = pmag_pkg::PMAG_REG_OTHER;
        if (a <= `PMAG_BOOT_LAST)
            r = pmag_pkg::PMAG_REG_BOOT;
        else if (a <= `PMAG_BLK0_LAST)
            r = pmag_pkg::PMAG_REG_BLK0;
        else if (a <= `PMAG_BLK1_LAST)
            r = pmag_pkg::PMAG_REG_BLK1;
        else if (a <= `PMAG_BLK2_LAST)
            r = pmag_pkg::PMAG_REG_BLK2;
        else if (a <= `PMAG_BLK3_LAST)
            r = HAS_BLOCK3 ? pmag_pkg::PMAG_REG_BLK3 : pmag_pkg::PMAG_REG_OTHER;
        else if (a >= `PMAG_ID_FIRST && a <= `PMAG_ID_LAST)
            r = pmag_pkg::PMAG_REG_ID;
        else if (a >= `PMAG_CFG_FIRST)
            r = pmag_pkg::PMAG_REG_CFG;
        return r;
    endfunction

    // R03 select one lock bit per block from low and high bytes
    function automatic logic lockOf(input pmag_pkg::pmag_region_t r,
                                    input logic [7:0] lo,
                                    input logic [7:0] hi);
        logic v;
        v = 1'b1;
        unique case (r)
            pmag_pkg::PMAG_REG_BOOT: v = hi[`PMAG_BIT_BOOT];
            pmag_pkg::PMAG_REG_BLK0: v = lo[0];
            pmag_pkg::PMAG_REG_BLK1: v = lo[1];
            pmag_pkg::PMAG_REG_BLK2: v = lo[2];
            pmag_pkg::PMAG_REG_BLK3: v = lo[3];
            pmag_pkg::PMAG_REG_ID,
            pmag_pkg::PMAG_REG_CFG,
            pmag_pkg::PMAG_REG_OTHER: v = 1'b1;
        endcase
        return v;
    endfunction

    assign tgtRegion = regionOf(tablePtr);
    assign pcRegion  = regionOf(execPc);
    assign extRegion = regionOf(extAddr);

    // Pin synchronisers
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            entryS1_q <= 1'b0;
            entryS2_q <= 1'b0;
            hvS1_q    <= 1'b0;
            hvS2_q    <= 1'b0;
        end else begin
            entryS1_q <= progEntryPin;
            entryS2_q <= entryS1_q;
            hvS1_q    <= highProgVoltage;
            hvS2_q    <= hvS1_q;
        end
    end

    // R19 low-voltage entry, R21 high-voltage entry always works
    assign progActive = hvS2_q || (dbgProg_q[`PMAG_BIT_LVP] && entryS2_q);

    // Session kind latched at entry
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            hvSession_q <= 1'b0;
        end else if (!progActive) begin
            hvSession_q <= 1'b0;
        end else if (hvS2_q) begin
            hvSession_q <= 1'b1;
        end
    end

    // Register write strobes
    logic cpuCfgWr, extCfgWr;
    logic [`PMAG_ADDR_W-1:0] cfgAddr;
    logic [7:0] cfgData;
    assign cpuCfgWr = tableWriteOp && !progActive && tgtRegion == pmag_pkg::PMAG_REG_CFG
                      && wrHi_q[`PMAG_BIT_CFGWR];
    assign extCfgWr = extWriteReq && progActive && !extEepromSel
                      && extRegion == pmag_pkg::PMAG_REG_CFG && wrHi_q[`PMAG_BIT_CFGWR];
    assign cfgAddr  = extCfgWr ? extAddr : tablePtr;
    assign cfgData  = extCfgWr ? extWrData : tableWrData;

    // Erase masks for per-block lock bits
    logic [7:0] eraseLo, eraseHi;
    always_comb begin
        eraseLo = `PMAG_ZERO_BYTE;
        eraseHi = `PMAG_ZERO_BYTE;
        // R11 erase only from the programmer
        if (progActive && extChipErase) begin
            eraseLo = `PMAG_ERASED;
            eraseHi = `PMAG_ERASED;
        end else if (progActive && extBlockErase) begin
            if (extEraseBlock == 3'd4)
                eraseHi[`PMAG_BIT_BOOT] = 1'b1;
            else
                eraseLo[extEraseBlock[1:0]] = 1'b1;
        end
    end

    // R04 lock bytes, R10 writes may only clear bits
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            extLo_q <= `PMAG_ERASED;
            extHi_q <= `PMAG_ERASED;
            wrLo_q  <= `PMAG_ERASED;
            wrHi_q  <= `PMAG_ERASED;
            xrdLo_q <= `PMAG_ERASED;
            xrdHi_q <= `PMAG_ERASED;
        end else begin
            extLo_q <= (extLo_q & ((cpuCfgWr || extCfgWr) && cfgAddr == `PMAG_REG_EXT_LO
                        ? cfgData : `PMAG_ERASED)) | eraseLo;
            extHi_q <= (extHi_q & ((cpuCfgWr || extCfgWr) && cfgAddr == `PMAG_REG_EXT_HI
                        ? cfgData : `PMAG_ERASED)) | eraseHi;
            wrLo_q  <= (wrLo_q & ((cpuCfgWr || extCfgWr) && cfgAddr == `PMAG_REG_WR_LO
                        ? cfgData : `PMAG_ERASED)) | eraseLo;
            // R14 config write lock bit cleared only externally
            wrHi_q  <= (wrHi_q & (extCfgWr && cfgAddr == `PMAG_REG_WR_HI ? cfgData
                        : (cpuCfgWr && cfgAddr == `PMAG_REG_WR_HI
                           ? (cfgData | (8'h01 << `PMAG_BIT_CFGWR)) : `PMAG_ERASED)))
                       | eraseHi;
            xrdLo_q <= (xrdLo_q & ((cpuCfgWr || extCfgWr) && cfgAddr == `PMAG_REG_XRD_LO
                        ? cfgData : `PMAG_ERASED)) | eraseLo;
            xrdHi_q <= (xrdHi_q & ((cpuCfgWr || extCfgWr) && cfgAddr == `PMAG_REG_XRD_HI
                        ? cfgData : `PMAG_ERASED)) | eraseHi;
        end
    end

    // R20 debug/LOW_VOLT_PROG_ENABLE byte erased to ones, R22 LOW_VOLT_PROG_ENABLE only in HV session
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            dbgProg_q <= `PMAG_ERASED;
        end else if (progActive && extChipErase) begin
            dbgProg_q <= `PMAG_ERASED;
        end else if ((cpuCfgWr || extCfgWr) && cfgAddr == `PMAG_REG_DBGPROG) begin
            dbgProg_q[`PMAG_BIT_DEBUG] <= cfgData[`PMAG_BIT_DEBUG];
            if (extCfgWr && hvSession_q)
                dbgProg_q[`PMAG_BIT_LVP] <= cfgData[`PMAG_BIT_LVP];
        end
    end

    // Config byte readback
    logic [7:0] cfgRd;
    always_comb begin
        unique case (tablePtr)
            `PMAG_REG_EXT_LO:  cfgRd = extLo_q;
            `PMAG_REG_EXT_HI:  cfgRd = extHi_q;
            `PMAG_REG_WR_LO:   cfgRd = wrLo_q;
            `PMAG_REG_WR_HI:   cfgRd = wrHi_q;
            `PMAG_REG_XRD_LO:  cfgRd = xrdLo_q;
            `PMAG_REG_XRD_HI:  cfgRd = xrdHi_q;
            `PMAG_REG_DBGPROG: cfgRd = dbgProg_q;
            default:           cfgRd = memRdData;
        endcase
    end

    // R23 table read filter in the same cycle, R05 CPU access paths
    logic sameBlock, xrdOpen;
    assign sameBlock = tgtRegion == pcRegion;
    assign xrdOpen   = lockOf(tgtRegion, xrdLo_q, xrdHi_q);
    always_comb begin
        tableRdData = `PMAG_ZERO_BYTE;
        if (tableReadOp) begin
            unique case (tgtRegion)
                // R16 ID bytes always readable, R15 reachable
                pmag_pkg::PMAG_REG_ID:    tableRdData = memRdData;
                pmag_pkg::PMAG_REG_CFG:   tableRdData = cfgRd;
                // R02 absent block reads zero
                pmag_pkg::PMAG_REG_OTHER: tableRdData = `PMAG_ZERO_BYTE;
                // R08 same block, R09 cross block zeros
                default:                  tableRdData = (xrdOpen || sameBlock)
                                                        ? memRdData : `PMAG_ZERO_BYTE;
            endcase
        end
    end

    // R07 table write lock, R06 external locks ignored for CPU
    always_comb begin
        memWrAllow = 1'b0;
        if (tableWriteOp) begin
            unique case (tgtRegion)
                pmag_pkg::PMAG_REG_ID:    memWrAllow = 1'b1;
                pmag_pkg::PMAG_REG_CFG,
                pmag_pkg::PMAG_REG_OTHER: memWrAllow = 1'b0;
                default:                  memWrAllow = lockOf(tgtRegion, wrLo_q, wrHi_q);
            endcase
        end
    end
    assign cfgWrAllow = cpuCfgWr || extCfgWr;

    // R13 CPU EEPROM access unaffected by locks
    assign cpuEepromAllow = cpuEepromReq;

    // R12 EEPROM locks, R06 external block locks, R14 config lock
    always_comb begin
        extAllow = 1'b0;
        if (progActive && (extReadReq || extWriteReq)) begin
            if (extEepromSel)
                extAllow = extHi_q[`PMAG_BIT_EEPROM]
                           && !(extWriteReq && !wrHi_q[`PMAG_BIT_EEPROM]);
            else if (extRegion == pmag_pkg::PMAG_REG_ID)
                extAllow = 1'b1;
            else if (extRegion == pmag_pkg::PMAG_REG_CFG)
                extAllow = extReadReq || wrHi_q[`PMAG_BIT_CFGWR];
            else if (extRegion == pmag_pkg::PMAG_REG_OTHER)
                extAllow = 1'b0;
            else
                extAllow = lockOf(extRegion, extLo_q, extHi_q)
                           && !(extWriteReq && !lockOf(extRegion, wrLo_q, wrHi_q));
        end
    end

    // R18 entry pin dedicated while LOW_VOLT_PROG_ENABLE set, R17 debugger enable
    assign progMode         = progActive;
    assign progEntryPinGpio = !dbgProg_q[`PMAG_BIT_LVP];
    assign debugEnable      = !dbgProg_q[`PMAG_BIT_DEBUG];
    assign toolPinsReserved = !dbgProg_q[`PMAG_BIT_DEBUG];

endmodule

// ===== verilog/pmag_pkg.sv
// Purpose: types for the program memory access guard
// Assumes: nothing
// Notes:   region decode result
package pmag_pkg;
    typedef enum logic [2:0] {
        PMAG_REG_BOOT,
        PMAG_REG_BLK0,
        PMAG_REG_BLK1,
        PMAG_REG_BLK2,
        PMAG_REG_BLK3,
        PMAG_REG_ID,
        PMAG_REG_CFG,
        PMAG_REG_OTHER
    } pmag_region_t;
endpackage
